// >>> logic_unit_params.svh
// Constants for the byte logic and rotate unit: opcode codes, lengths,
// cycle counts. Assumes inclusion by bare name from the design files.
`ifndef LOGIC_UNIT_PARAMS_SVH
`define LOGIC_UNIT_PARAMS_SVH

// Operation codes on the op input
`define OPC_AND 4'h0
`define OPC_OR 4'h1
`define OPC_XOR 4'h2
`define OPC_CLR 4'h3
`define OPC_CPL 4'h4
`define OPC_RL 4'h5
`define OPC_RLC 4'h6
`define OPC_RR 4'h7
`define OPC_RRC 4'h8
`define OPC_SWAP 4'h9

// Operand form codes on the form input
`define FRM_BANK 3'h0
`define FRM_DIRECT 3'h1
`define FRM_INDIRECT 3'h2
`define FRM_IMM 3'h3
`define FRM_DIR_ACC 3'h4
`define FRM_DIR_IMM 3'h5

// Instruction lengths in bytes
`define LEN_ONE 2'h1
`define LEN_TWO 2'h2
`define LEN_THREE 2'h3

// Cycle counts
`define CYC_ONE 2'h1
`define CYC_TWO 2'h2
`define CYC_THREE 2'h3

// Accumulator and carry after reset
`define ACC_RESET 8'h00
`define CARRY_RESET 1'h0

`endif

// >>> logic_unit_pkg.sv
// Types for the byte logic and rotate unit.
// Assumes the params header supplies the opcode and form codes; state codes are set here.
package logic_unit_pkg;
    typedef enum logic [2:0] {
        st_idle = 3'h1,
        st_busy = 3'h2,
        st_done = 3'h4
    } state_type;
endpackage : logic_unit_pkg

// >>> byte_combine.sv
// Bitwise combiner: AND, OR or XOR of two bytes, one gate per bit.
// Assumes a purely combinational use inside the sequencer.
`timescale 1ns/10ps
`include "logic_unit_params.svh"
module byte_combine #(
    parameter int WIDTH = 8
) (
    // Operation select
    input wire logic [3:0] op,
    // Operands and result
    input wire logic [WIDTH-1:0] left,
    input wire logic [WIDTH-1:0] right,
    output logic [WIDTH-1:0] result
);
    // Each result bit sees only its own operand bits; one continuous
    // assignment per bit keeps every bit to a single driver
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        assign result[i] = (op == `OPC_OR) ? (left[i] | right[i]) :
            (op == `OPC_XOR) ? (left[i] ^ right[i]) :
            (left[i] & right[i]);
    end
endmodule : byte_combine

// >>> byte_logic_rotate_unit.sv
// Byte logic and rotate unit: runs logic, clear, complement, rotate and
// swap instructions on the accumulator and carry, writing direct bytes.
// Assumes the core presents the operand for the chosen form with start,
// and keeps op, form and operand steady until done.
// Overview of operation
// - Logical operations combine the operands bit by bit only.
// - AND bank register to accumulator: one byte, one cycle.
// - AND direct byte to accumulator: two bytes, two cycles.
// - AND indirect RAM to accumulator: one byte, two cycles.
// - AND immediate to accumulator: two bytes, two cycles.
// - AND accumulator into direct byte: two bytes, three cycles.
// - AND immediate into direct byte: three bytes, three cycles.
// - OR has the same six forms, lengths and cycle counts as AND.
// - XOR has the same six forms, lengths and cycle counts as AND.
// - Plain rotates move the accumulator one place, carry untouched.
// - Rotate left through carry: bit 7 to carry, carry to bit 0.
// - Rotate right through carry: bit 0 to carry, carry to bit 7.
// - Swap exchanges accumulator nibbles in one byte, one cycle.
`timescale 1ns/10ps
`include "logic_unit_params.svh"
module byte_logic_rotate_unit #(
    parameter int WIDTH = 8
) (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    // Instruction issue
    input wire logic start,
    input wire logic [3:0] op,
    input wire logic [2:0] form,
    input wire logic [WIDTH-1:0] operand,
    input wire logic [WIDTH-1:0] imm_data,
    // Architectural state and results
    output logic [WIDTH-1:0] acc,
    output logic carry,
    output logic [WIDTH-1:0] direct_wdata,
    output logic direct_we,
    output logic done,
    output logic busy,
    output logic [1:0] instr_len,
    output logic [1:0] instr_cycles
);
    logic_unit_pkg::state_type state;
    logic [1:0] count;
    logic [1:0] next_len;
    logic [1:0] next_cycles;
    logic [WIDTH-1:0] combined;
    logic [WIDTH-1:0] rhs;
    logic [WIDTH-1:0] lhs;
    logic is_logic;
    logic to_direct;
    logic finish;

    assign is_logic = (op == `OPC_AND) || (op == `OPC_OR) ||
        (op == `OPC_XOR);
    assign to_direct = is_logic &&
        ((form == `FRM_DIR_ACC) || (form == `FRM_DIR_IMM));

    // Operand steering: the direct-with-immediate form pairs the fetched
    // byte with the constant, every other form pairs it with acc
    always_comb begin
        if (is_logic && form == `FRM_DIR_IMM) begin
            lhs = operand;
            rhs = imm_data;
        end else if (is_logic && form == `FRM_DIR_ACC) begin
            lhs = operand;
            rhs = acc;
        end else begin
            lhs = acc;
            rhs = operand;
        end
    end

    byte_combine #(.WIDTH(WIDTH)) u_combine (
        .op(op),
        .left(lhs),
        .right(rhs),
        .result(combined)
    );

    // Length and timing per form; shared by AND, OR and XOR alike
    always_comb begin
        next_len = `LEN_ONE;
        next_cycles = `CYC_ONE;
        if (is_logic) begin
            if (form == `FRM_BANK) begin
                next_len = `LEN_ONE;
                next_cycles = `CYC_ONE;
            end else if (form == `FRM_DIRECT) begin
                next_len = `LEN_TWO;
                next_cycles = `CYC_TWO;
            end else if (form == `FRM_INDIRECT) begin
                next_len = `LEN_ONE;
                next_cycles = `CYC_TWO;
            end else if (form == `FRM_IMM) begin
                next_len = `LEN_TWO;
                next_cycles = `CYC_TWO;
            end else if (form == `FRM_DIR_ACC) begin
                next_len = `LEN_TWO;
                next_cycles = `CYC_THREE;
            end else begin
                next_len = `LEN_THREE;
                next_cycles = `CYC_THREE;
            end
        end
    end

    // Finishing cycle: a one-cycle instruction finishes at issue
    assign finish = ce && (((state == logic_unit_pkg::st_idle) && start &&
        (next_cycles == `CYC_ONE)) ||
        ((state == logic_unit_pkg::st_busy) && (count == 2'h1)));

    // Sequencer: idle, busy for multi-cycle forms, done pulse
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state <= logic_unit_pkg::st_idle;
            count <= 2'h0;
        end else if (ce) begin
            case (state)
                logic_unit_pkg::st_idle: begin
                    if (start && next_cycles != `CYC_ONE) begin
                        state <= logic_unit_pkg::st_busy;
                        count <= next_cycles - 2'h1;
                    end else if (start) begin
                        state <= logic_unit_pkg::st_done;
                    end
                end
                logic_unit_pkg::st_busy: begin
                    count <= count - 2'h1;
                    if (count == 2'h1) begin
                        state <= logic_unit_pkg::st_done;
                    end
                end
                logic_unit_pkg::st_done: begin
                    state <= logic_unit_pkg::st_idle;
                end
                default: begin
                    state <= logic_unit_pkg::st_idle;
                end
            endcase
        end
    end

    // Status outputs, all registered
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            busy <= 1'b0;
            done <= 1'b0;
            instr_len <= 2'h0;
            instr_cycles <= 2'h0;
        end else if (ce) begin
            done <= finish;
            busy <= (state == logic_unit_pkg::st_idle) ? (start &&
                next_cycles != `CYC_ONE) :
                (state == logic_unit_pkg::st_busy && count != 2'h1);
            if (state == logic_unit_pkg::st_idle && start) begin
                instr_len <= next_len;
                instr_cycles <= next_cycles;
            end
        end
    end

    // Accumulator and carry update at the finishing cycle only, so
    // a multi-cycle form never shows a half-done value
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            acc <= `ACC_RESET;
            carry <= `CARRY_RESET;
        end else if (finish) begin
            case (op)
                `OPC_AND, `OPC_OR, `OPC_XOR: begin
                    if (!to_direct) begin
                        acc <= combined;
                    end
                end
                `OPC_CLR: acc <= '0;
                `OPC_CPL: acc <= ~acc;
                `OPC_RL: acc <= {acc[WIDTH-2:0], acc[WIDTH-1]};
                `OPC_RR: acc <= {acc[0], acc[WIDTH-1:1]};
                `OPC_RLC: begin
                    acc <= {acc[WIDTH-2:0], carry};
                    carry <= acc[WIDTH-1];
                end
                `OPC_RRC: begin
                    acc <= {carry, acc[WIDTH-1:1]};
                    carry <= acc[0];
                end
                `OPC_SWAP: begin
                    acc <= {acc[WIDTH/2-1:0], acc[WIDTH-1:WIDTH/2]};
                end
                default: acc <= acc;
            endcase
        end
    end

    // Write-back to the direct byte, one strobe at the end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            direct_we <= 1'b0;
            direct_wdata <= '0;
        end else if (ce) begin
            direct_we <= finish && to_direct;
            if (finish && to_direct) begin
                direct_wdata <= combined;
            end
        end
    end

    // Assertions
    sequence s_issue_one;
        ce && state == logic_unit_pkg::st_idle && start &&
            is_logic && form == `FRM_BANK;
    endsequence
    sequence s_issue_three;
        ce && state == logic_unit_pkg::st_idle && start && to_direct;
    endsequence

    a_bank_one_cycle: assert property (
        @(posedge clk) disable iff (!rstn)
        s_issue_one |=> done && instr_cycles == 2'h1)
        else $error("bank form did not finish in one cycle");
    a_direct_three_cycles: assert property (
        @(posedge clk) disable iff (!rstn)
        s_issue_three ##1 ce[*2] |=> done && direct_we)
        else $error("direct write-back not after three cycles");
    a_indirect_len: assert property (
        @(posedge clk) disable iff (!rstn)
        ce && state == logic_unit_pkg::st_idle && start && is_logic &&
        form == `FRM_INDIRECT |=> instr_len == 2'h1 &&
        instr_cycles == 2'h2 && busy)
        else $error("indirect form length or timing wrong");
    a_dir_imm_len: assert property (
        @(posedge clk) disable iff (!rstn)
        ce && state == logic_unit_pkg::st_idle && start && is_logic &&
        form == `FRM_DIR_IMM |=> instr_len == 2'h3)
        else $error("direct immediate form length wrong");
    a_rlc_ring: assert property (
        @(posedge clk) disable iff (!rstn)
        finish && op == `OPC_RLC |=> carry == $past(acc[WIDTH-1]) &&
        acc[0] == $past(carry))
        else $error("rotate left through carry wrong");
    a_rrc_ring: assert property (
        @(posedge clk) disable iff (!rstn)
        finish && op == `OPC_RRC |=> carry == $past(acc[0]) &&
        acc[WIDTH-1] == $past(carry))
        else $error("rotate right through carry wrong");
    // Checks the rotated value too, so a stuck acc cannot slip through
    a_rotate_keeps_carry: assert property (
        @(posedge clk) disable iff (!rstn)
        finish && (op == `OPC_RL || op == `OPC_RR) |=> $stable(carry) &&
        acc == (($past(op) == `OPC_RL) ?
        {$past(acc[WIDTH-2:0]), $past(acc[WIDTH-1])} :
        {$past(acc[0]), $past(acc[WIDTH-1:1])}))
        else $error("plain rotate wrong or touched carry");
    a_swap_nibbles: assert property (
        @(posedge clk) disable iff (!rstn)
        finish && op == `OPC_SWAP |=> acc ==
        {$past(acc[WIDTH/2-1:0]), $past(acc[WIDTH-1:WIDTH/2])})
        else $error("nibble swap wrong");
    a_clear_zero: assert property (
        @(posedge clk) disable iff (!rstn)
        finish && op == `OPC_CLR |=> acc == '0)
        else $error("clear left bits set");
    a_xor_bitwise: assert property (
        @(posedge clk) disable iff (!rstn)
        finish && op == `OPC_XOR && form == `FRM_IMM |=>
        acc == ($past(acc) ^ $past(operand)))
        else $error("xor result wrong");
    a_or_direct_two: assert property (
        @(posedge clk) disable iff (!rstn)
        ce && state == logic_unit_pkg::st_idle && start &&
        op == `OPC_OR && form == `FRM_DIRECT ##1 ce |=> done)
        else $error("or direct not done in two cycles");
endmodule : byte_logic_rotate_unit

// >>> test_byte_logic_rotate_unit.sv
// Self-checking bench for the byte logic and rotate unit.
// Assumes the params header codes and a 125 MHz core clock.
`timescale 1ns/10ps
`include "logic_unit_params.svh"
module test_byte_logic_rotate_unit;
    typedef struct {
        logic [3:0] op;
        logic [2:0] form;
        logic [7:0] opd, imm, acc;
        logic cy, we;
        logic [7:0] wd;
        logic [1:0] len, cyc;
    } row_type;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic ce = 1'b1;
    logic start = 1'b0;
    logic [3:0] op = 4'h0;
    logic [2:0] form = 3'h0;
    logic [7:0] operand = 8'h00;
    logic [7:0] imm_data = 8'h00;
    logic [7:0] acc, direct_wdata;
    logic carry, direct_we, done, busy;
    logic [1:0] instr_len, instr_cycles;
    int n_errors = 0;
    int total_checks = 0;
    int cycles = 0;
    int n;
    row_type rows [26];

    byte_logic_rotate_unit #(.WIDTH(8)) byte_logic_rotate_unit_i (
        .clk(clk), .rstn(rstn), .ce(ce), .start(start), .op(op),
        .form(form), .operand(operand), .imm_data(imm_data), .acc(acc),
        .carry(carry), .direct_wdata(direct_wdata), .direct_we(direct_we),
        .done(done), .busy(busy), .instr_len(instr_len),
        .instr_cycles(instr_cycles));

    // 8 ns core clock
    initial begin
        forever #4 clk = ~clk;
    end

    // Hang guard, far above the hundred-odd cycles the tests need
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_errors++;
            close_out();
        end
    end

    task automatic check(input string what, input logic [7:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Issue at a falling edge; n counts edges up to done, bounded
    task automatic issue(input logic [3:0] o, input logic [2:0] f,
                         input logic [7:0] d, i, input logic hold,
                         output int cnt);
        @(negedge clk);
        start = 1'b1;
        op = o;
        form = f;
        operand = d;
        imm_data = i;
        @(posedge clk);
        @(negedge clk);
        if (!hold) start = 1'b0;
        cnt = 1;
        while (done !== 1'b1 && cnt < 8) begin
            check("busy", {7'h00, busy}, 8'h01);
            @(negedge clk);
            cnt++;
        end
        check("busy_end", {7'h00, busy}, 8'h00);
    endtask : issue

    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : close_out

    initial begin
        // Chained rows: each expected acc follows from the row before
        rows = '{
        '{`OPC_CPL, 3'h0, 8'h00, 8'h00, 8'hFF, 0, 0, 8'h00, 2'h1, 2'h1},
        '{`OPC_AND, 3'h0, 8'h5A, 8'h00, 8'h5A, 0, 0, 8'h00, 2'h1, 2'h1},
        '{`OPC_OR, 3'h1, 8'h81, 8'h00, 8'hDB, 0, 0, 8'h00, 2'h2, 2'h2},
        '{`OPC_XOR, 3'h2, 8'h0F, 8'h00, 8'hD4, 0, 0, 8'h00, 2'h1, 2'h2},
        '{`OPC_AND, 3'h3, 8'hF0, 8'h00, 8'hD0, 0, 0, 8'h00, 2'h2, 2'h2},
        '{`OPC_XOR, 3'h4, 8'h33, 8'h00, 8'hD0, 0, 1, 8'hE3, 2'h2, 2'h3},
        '{`OPC_OR, 3'h5, 8'h0C, 8'h30, 8'hD0, 0, 1, 8'h3C, 2'h3, 2'h3},
        '{`OPC_RL, 3'h0, 8'h00, 8'h00, 8'hA1, 0, 0, 8'h00, 2'h1, 2'h1},
        '{`OPC_RLC, 3'h0, 8'h00, 8'h00, 8'h42, 1, 0, 8'h00, 2'h1, 2'h1},
        '{`OPC_RR, 3'h0, 8'h00, 8'h00, 8'h21, 1, 0, 8'h00, 2'h1, 2'h1},
        '{`OPC_RL, 3'h0, 8'h00, 8'h00, 8'h42, 1, 0, 8'h00, 2'h1, 2'h1},
        '{`OPC_RRC, 3'h0, 8'h00, 8'h00, 8'hA1, 0, 0, 8'h00, 2'h1, 2'h1},
        '{`OPC_SWAP, 3'h0, 8'h00, 8'h00, 8'h1A, 0, 0, 8'h00, 2'h1, 2'h1},
        '{`OPC_CLR, 3'h0, 8'h00, 8'h00, 8'h00, 0, 0, 8'h00, 2'h1, 2'h1},
        '{`OPC_OR, 3'h0, 8'h3C, 8'h00, 8'h3C, 0, 0, 8'h00, 2'h1, 2'h1},
        '{`OPC_XOR, 3'h0, 8'hFF, 8'h00, 8'hC3, 0, 0, 8'h00, 2'h1, 2'h1},
        '{`OPC_AND, 3'h1, 8'h0F, 8'h00, 8'h03, 0, 0, 8'h00, 2'h2, 2'h2},
        '{`OPC_XOR, 3'h1, 8'h5C, 8'h00, 8'h5F, 0, 0, 8'h00, 2'h2, 2'h2},
        '{`OPC_OR, 3'h2, 8'h80, 8'h00, 8'hDF, 0, 0, 8'h00, 2'h1, 2'h2},
        '{`OPC_AND, 3'h2, 8'h91, 8'h00, 8'h91, 0, 0, 8'h00, 2'h1, 2'h2},
        '{`OPC_OR, 3'h3, 8'h06, 8'h00, 8'h97, 0, 0, 8'h00, 2'h2, 2'h2},
        '{`OPC_XOR, 3'h3, 8'hFF, 8'h00, 8'h68, 0, 0, 8'h00, 2'h2, 2'h2},
        '{`OPC_AND, 3'h4, 8'hF0, 8'h00, 8'h68, 0, 1, 8'h60, 2'h2, 2'h3},
        '{`OPC_OR, 3'h4, 8'h01, 8'h00, 8'h68, 0, 1, 8'h69, 2'h2, 2'h3},
        '{`OPC_AND, 3'h5, 8'h3C, 8'h0F, 8'h68, 0, 1, 8'h0C, 2'h3, 2'h3},
        '{`OPC_XOR, 3'h5, 8'h55, 8'hFF, 8'h68, 0, 1, 8'hAA, 2'h3, 2'h3}};
        // Reset held 12 cycles, outputs cleared meanwhile
        repeat (12) @(negedge clk);
        check("acc_rst", acc, 8'h00);
        check("flags_rst", {4'h0, carry, direct_we, done, busy},
              8'h00);
        rstn = 1'b1;
        $display("test reset done");
        foreach (rows[k]) begin
            issue(rows[k].op, rows[k].form, rows[k].opd, rows[k].imm,
                  1'b0, n);
            check("cycles", 8'(n), {6'h00, rows[k].cyc});
            check("acc", acc, rows[k].acc);
            check("carry", {7'h00, carry}, {7'h00, rows[k].cy});
            check("we", {7'h00, direct_we}, {7'h00, rows[k].we});
            if (rows[k].we)
                check("wdata", direct_wdata, rows[k].wd);
            check("len", {6'h00, instr_len}, {6'h00, rows[k].len});
            check("icyc", {6'h00, instr_cycles}, {6'h00, rows[k].cyc});
        end
        $display("test table done");
        // Unknown op code finishes at once and leaves acc alone
        issue(4'hC, 3'h0, 8'hFF, 8'h00, 1'b0, n);
        check("unk_cyc", 8'(n), 8'h01);
        check("unk_acc", acc, 8'h68);
        // Start held high through busy, dropped once done shows: only one operation
        issue(`OPC_AND, `FRM_DIR_ACC, 8'h0F, 8'h00, 1'b1, n);
        check("hold_cyc", 8'(n), 8'h03);
        check("hold_wd", direct_wdata, 8'h08);
        start = 1'b0;
        repeat (3) begin
            @(negedge clk);
            check("hold_again", {6'h00, done, direct_we}, 8'h00);
        end
        $display("test held start done");
        // Clock enable low freezes a two-cycle operation mid-way
        @(negedge clk);
        start = 1'b1;
        op = `OPC_XOR;
        form = `FRM_DIRECT;
        operand = 8'hFF;
        @(negedge clk);
        start = 1'b0;
        ce = 1'b0;
        repeat (4) begin
            @(negedge clk);
            check("frozen", {6'h00, done, busy}, 8'h01);
        end
        // First edge with ce high again is the finishing edge
        ce = 1'b1;
        @(negedge clk);
        check("ce_one", {7'h00, done}, 8'h01);
        check("ce_acc", acc, 8'h97);
        @(negedge clk);
        check("ce_two", {7'h00, done}, 8'h00);
        $display("test clock enable done");
        // Set carry so that the reset below has something to clear
        issue(`OPC_RLC, 3'h0, 8'h00, 8'h00, 1'b0, n);
        check("pre_rst_acc", acc, 8'h2E);
        check("pre_rst_cy", {7'h00, carry}, 8'h01);
        // Reset in mid-run clears state at once
        @(negedge clk);
        start = 1'b1;
        op = `OPC_OR;
        form = `FRM_DIR_IMM;
        @(negedge clk);
        start = 1'b0;
        rstn = 1'b0;
        @(negedge clk);
        check("mid_acc", acc, 8'h00);
        check("mid_flags", {4'h0, carry, direct_we, done, busy},
              8'h00);
        rstn = 1'b1;
        issue(`OPC_CPL, 3'h0, 8'h00, 8'h00, 1'b0, n);
        check("after_rst", acc, 8'hFF);
        $display("test mid reset done");
        close_out();
    end
endmodule : test_byte_logic_rotate_unit
